// File: tcs_synth_ctrl.sv
// Synthesizer controller: keypad, channel state, divide ratio, PLL dividers, display.
// Assumes all inputs are synchronous to mclk; keypad columns idle high.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: Straps pick Europe, USA or Japan table
// RULE_02: Two digit keys select and tune channel
// RULE_03: Table ratio loads divide-ratio registers and divider
// RULE_04: Phase comparator drives pump from divider outputs
// RULE_05: External prescaler makes the counted input
// RULE_06: Key 10 toggles channel/frequency view and lamps
// RULE_07: Key 11 discards a pending tens digit
// RULE_08: Key 12 lowers ratio by one step
// RULE_09: Key 13 raises ratio by one step
// RULE_10: Key 15 searches upward every 350 ms
// RULE_11: Search wraps from last to first channel
// RULE_12: Key 14 stops search, keeps channel
// RULE_13: Display toggle works during search
// RULE_14: Reset tunes and shows first channel
// RULE_15: Frequency shows truncated to 100 kHz
// RULE_16: Missing channel entry acts as reset
// RULE_17: Search visits only existing channels
// RULE_18: Ratio counts 62.5 kHz units
// RULE_19: Exactly one band output per channel
// RULE_20: Keypad scanned, debounced, one action per press
module tcs_synth_ctrl #(
  parameter int DEB_CYC  = tcs_pkg::DEBOUNCE_CYC, // Debounce length in cycles
  parameter int CHANNEL_SEARCH_KEY_CYC = tcs_pkg::SEARCH_CYC    // Search step in cycles
) (
  input  wire logic               mclk,          // Clock, 250 MHz
  input  wire logic               nrst,          // Sync reset, active low
  input  wire logic               country_sel_a, // Country select bit a
  input  wire logic               country_sel_b, // Country select bit b
  input  wire logic               cfg_strap_0,   // Ignored strap
  input  wire logic               cfg_strap_1,   // Synth mode strap
  input  wire logic               cfg_strap_2,   // Synth mode strap
  input  wire logic [3:0]         key_col_n,     // Keypad columns, low = pressed
  input  wire logic               fin,           // Prescaled oscillator input
  output var  logic [3:0]         key_row_n,     // Keypad row drive, low = active
  output var  logic [7:0]         ratio_hi,      // Divide ratio, high byte
  output var  logic [7:0]         ratio_lo,      // Divide ratio, low byte
  output var  tcs_pkg::tcs_pump_t pump,          // Phase comparator output
  output var  tcs_pkg::tcs_band_t band,          // Band select
  output var  tcs_pkg::tcs_disp_t disp           // Display digits and lamps
);
  import tcs_pkg::*;

  function automatic logic [6:0] first_ch(input tcs_country_t c);
    case (c)
      CTRY_USA: first_ch = USA_FIRST;
      CTRY_JPN: first_ch = JPN_FIRST;
      default:  first_ch = EUR_FIRST;
    endcase
  endfunction

  function automatic logic [6:0] last_ch(input tcs_country_t c);
    case (c)
      CTRY_USA: last_ch = USA_LAST;
      CTRY_JPN: last_ch = JPN_LAST;
      default:  last_ch = EUR_LAST;
    endcase
  endfunction

  // Binary to four BCD digits by shift and add
  function automatic logic [15:0] to_bcd(input logic [13:0] bin);
    logic [29:0] sh;
    sh = {16'h0000, bin};
    for (int i = 0; i < 14; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[14+4*d +: 4] > 4'h4) sh[14+4*d +: 4] = sh[14+4*d +: 4] + 4'h3;
      end
      sh = sh << 1;
    end
    to_bcd = sh[29:14];
  endfunction

  // Strap decode, caught while reset is held
  tcs_country_t strap_ctry;
  tcs_country_t country_reg;
  tcs_country_t country_next;
  always_comb begin
    strap_ctry = CTRY_EUR;
    if (cfg_strap_1 && cfg_strap_2) begin
      if (!country_sel_a && country_sel_b) strap_ctry = CTRY_USA; // RULE_01
      else if (country_sel_a && country_sel_b) strap_ctry = CTRY_JPN; // RULE_01
    end
    country_next = nrst ? country_reg : strap_ctry;
  end

  always_ff @(posedge mclk) begin
    country_reg <= country_next;
  end

  // Keypad scanner and debouncer
  tcs_key_st_t ks_reg;
  tcs_key_st_t ks_next;
  logic [31:0] kcnt_reg;
  logic [31:0] kcnt_next;
  logic [1:0]  row_reg;
  logic [1:0]  row_next;
  logic [3:0]  code_reg;
  logic [3:0]  code_next;
  logic        evt_reg;
  logic        evt_next;
  logic [3:0]  row_n_next;
  logic [3:0]  col;
  logic [1:0]  col_idx;
  always_comb begin
    col = ~key_col_n;
    col_idx = col[0] ? 2'd0 : col[1] ? 2'd1 : col[2] ? 2'd2 : 2'd3;
    ks_next = ks_reg;
    kcnt_next = kcnt_reg + 32'd1;
    row_next = row_reg;
    code_next = code_reg;
    evt_next = 1'b0;
    case (ks_reg)
      KS_SCAN: begin
        if (kcnt_reg == SCAN_CYC - 1) begin
          kcnt_next = '0;
          if (|col) begin
            code_next = {row_reg, col_idx};
            ks_next = KS_DEB;
          end else begin
            row_next = row_reg + 2'd1;
          end
        end
      end
      KS_DEB: begin
        if (!col[code_reg[1:0]]) begin
          kcnt_next = '0;
          ks_next = KS_SCAN;
        end else if (kcnt_reg == DEB_CYC - 1) begin
          evt_next = 1'b1; // RULE_20
          ks_next = KS_HELD;
        end
      end
      KS_HELD: begin
        kcnt_next = '0;
        if (!col[code_reg[1:0]]) ks_next = KS_REL;
      end
      KS_REL: begin
        if (col[code_reg[1:0]]) begin
          kcnt_next = '0;
          ks_next = KS_HELD;
        end else if (kcnt_reg == DEB_CYC - 1) begin
          kcnt_next = '0;
          ks_next = KS_SCAN;
        end
      end
      default: ks_next = KS_SCAN;
    endcase
    row_n_next = ~(4'h1 << row_next);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ks_reg <= KS_SCAN;
      kcnt_reg <= '0;
      row_reg <= 2'h0;
      code_reg <= 4'h0;
      evt_reg <= 1'b0;
      key_row_n <= 4'he;
    end else begin
      ks_reg <= ks_next;
      kcnt_reg <= kcnt_next;
      row_reg <= row_next;
      code_reg <= code_next;
      evt_reg <= evt_next;
      key_row_n <= row_n_next;
    end
  end

  // Channel, entry, search and divide-ratio control
  tcs_mode_t   mode_reg;
  tcs_mode_t   mode_next;
  logic [6:0]  chan_reg;
  logic [6:0]  chan_next;
  logic [6:0]  entry_num;
  logic [6:0]  lo_ch;
  logic [6:0]  hi_ch;
  logic [3:0]  tens_reg;
  logic [3:0]  tens_next;
  logic        tens_vld_reg;
  logic        tens_vld_next;
  logic        show_freq_reg;
  logic        show_freq_next;
  logic [31:0] scnt_reg;
  logic [31:0] scnt_next;
  logic        ld1_reg;
  logic        ld1_next;
  logic        ld2_reg;
  logic [15:0] ratio_reg;
  logic [15:0] ratio_next;
  tcs_band_t   band_next;
  tcs_chan_t   rom_entry;
  always_comb begin
    lo_ch = first_ch(country_reg);
    hi_ch = last_ch(country_reg);
    entry_num = {tens_reg, 3'b000} + {2'b00, tens_reg, 1'b0} + {3'b000, code_reg};
    mode_next = mode_reg;
    chan_next = chan_reg;
    tens_next = tens_reg;
    tens_vld_next = tens_vld_reg;
    show_freq_next = show_freq_reg;
    scnt_next = scnt_reg;
    ld1_next = 1'b0;
    ratio_next = ratio_reg;
    band_next = band;
    if (!nrst) begin
      mode_next = MD_MANUAL;
      chan_next = first_ch(strap_ctry); // RULE_14
      tens_vld_next = 1'b0;
      show_freq_next = 1'b0; // RULE_14
      scnt_next = '0;
      ld1_next = 1'b1; // RULE_14
      ratio_next = RATIO_RST;
      band_next = BND_LO;
    end else begin
      // Timed step; a key in the same cycle delays it by one cycle unless it stops the search or restarts the count
      if (mode_reg == MD_SEARCH) begin
        if (scnt_reg != CHANNEL_SEARCH_KEY_CYC - 1) begin
          scnt_next = scnt_reg + 32'd1;
        end else if (!evt_reg) begin
          scnt_next = '0;
          ld1_next = 1'b1; // RULE_10
          chan_next = (chan_reg >= hi_ch) ? lo_ch : chan_reg + 7'd1; // RULE_11 RULE_17
        end
      end
      if (evt_reg && code_reg <= LAST_DIGIT_KEY) begin
        if (!tens_vld_reg) begin
          tens_next = code_reg;
          tens_vld_next = 1'b1;
        end else begin
          tens_vld_next = 1'b0;
          mode_next = MD_MANUAL;
          ld1_next = 1'b1; // RULE_02
          chan_next = (entry_num >= lo_ch && entry_num <= hi_ch) ? entry_num : lo_ch; // RULE_16
        end
      end
      if (evt_reg) begin
        case (code_reg)
          DISPLAY_TOGGLE_KEY: show_freq_next = !show_freq_reg; // RULE_06 RULE_13
          CLEAR_DIGIT_KEY: tens_vld_next = 1'b0; // RULE_07
          FINE_TUNE_DOWN_KEY: begin
            if (ratio_reg > RATIO_MIN) ratio_next = ratio_reg - 16'd1; // RULE_08 RULE_18
          end
          FINE_TUNE_UP_KEY: begin
            if (ratio_reg < RATIO_MAX) ratio_next = ratio_reg + 16'd1; // RULE_09 RULE_18
          end
          SEARCH_STOP_KEY: mode_next = MD_MANUAL; // RULE_12
          CHANNEL_SEARCH_KEY: begin
            mode_next = MD_SEARCH; // RULE_10
            scnt_next = '0;
          end
          default: ;
        endcase
      end
      // Table value replaces any fine tuning once the read settles
      if (ld2_reg) begin
        ratio_next = rom_entry.ratio; // RULE_03
        band_next = rom_entry.band; // RULE_19
      end
    end
  end

  always_ff @(posedge mclk) begin
    mode_reg <= mode_next;
    chan_reg <= chan_next;
    tens_reg <= tens_next;
    tens_vld_reg <= tens_vld_next;
    show_freq_reg <= show_freq_next;
    scnt_reg <= scnt_next;
    ld1_reg <= ld1_next;
    ld2_reg <= ld1_reg;
    ratio_reg <= ratio_next;
    band <= band_next;
  end

  assign ratio_hi = ratio_reg[15:8];
  assign ratio_lo = ratio_reg[7:0];

  tcs_chan_rom u_rom (
    .mclk    (mclk),
    .nrst    (nrst),
    .country (country_reg),
    .chan    (chan_reg),
    .entry   (rom_entry)
  );

  // Variable divider, reference divider, phase comparator
  logic        fin_d_reg;
  logic [15:0] vcnt_reg;
  logic [15:0] vcnt_next;
  logic [15:0] rcnt_reg;
  logic [15:0] rcnt_next;
  logic        vpls_reg;
  logic        vpls_next;
  logic        rpls_reg;
  logic        rpls_next;
  tcs_pump_t   pump_next;
  always_comb begin
    vcnt_next = vcnt_reg;
    vpls_next = 1'b0;
    if (fin && !fin_d_reg) begin
      if (vcnt_reg <= 16'd1) begin
        vcnt_next = ratio_reg; // RULE_03
        vpls_next = 1'b1;
      end else begin
        vcnt_next = vcnt_reg - 16'd1;
      end
    end
    rpls_next = (rcnt_reg <= 16'd1);
    rcnt_next = rpls_next ? REF_DIV : rcnt_reg - 16'd1;
    pump_next.up = pump.up | rpls_reg;
    pump_next.dn = pump.dn | vpls_reg;
    if (pump_next.up && pump_next.dn) pump_next = '0; // RULE_04
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fin_d_reg <= 1'b0;
      vcnt_reg <= RATIO_RST;
      rcnt_reg <= REF_DIV;
      vpls_reg <= 1'b0;
      rpls_reg <= 1'b0;
      pump <= '0;
    end else begin
      fin_d_reg <= fin;
      vcnt_reg <= vcnt_next;
      rcnt_reg <= rcnt_next;
      vpls_reg <= vpls_next;
      rpls_reg <= rpls_next;
      pump <= pump_next;
    end
  end

  // Display: channel number or frequency in tenths of MHz
  tcs_disp_t   disp_next;
  logic [18:0] freq_x5;
  logic [15:0] fbcd;
  logic [15:0] cbcd;
  always_comb begin
    freq_x5 = {3'b000, ratio_reg} + {1'b0, ratio_reg, 2'b00};
    fbcd = to_bcd(freq_x5[16:3]); // RULE_15
    cbcd = to_bcd({7'h00, chan_reg});
    disp_next.digits = show_freq_reg ? fbcd : {BCD_BLANK, BCD_BLANK, cbcd[7:0]};
    disp_next.dp = show_freq_reg ? DP_TENTHS : 4'h0;
    disp_next.ch_led = !show_freq_reg; // RULE_06
    disp_next.fr_led = show_freq_reg; // RULE_06
  end

  always_ff @(posedge mclk) begin
    if (!nrst) disp <= '{{BCD_BLANK, BCD_BLANK, 8'h00}, 4'h0, 1'b1, 1'b0};
    else disp <= disp_next;
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_key_once: assert property (evt_reg |=> !evt_reg [*2]) // RULE_20
    else $error("key acted twice");
  a_ratio_load: assert property (ld2_reg |=> ratio_reg == $past(rom_entry.ratio)) // RULE_03
    else $error("ratio not loaded from table");
  a_fine_down: assert property (evt_reg && code_reg == FINE_TUNE_DOWN_KEY && !ld2_reg // RULE_08
    && ratio_reg > RATIO_MIN |=> ratio_reg == $past(ratio_reg) - 16'd1)
    else $error("fine down step wrong");
  a_fine_up: assert property (evt_reg && code_reg == FINE_TUNE_UP_KEY && !ld2_reg && ratio_reg < RATIO_MAX // RULE_09
    |=> ratio_reg == $past(ratio_reg) + 16'd1)
    else $error("fine up step wrong");
  a_search_step: assert property (mode_reg == MD_SEARCH && scnt_reg == CHANNEL_SEARCH_KEY_CYC - 1 && !evt_reg // RULE_10
    && chan_reg < hi_ch |=> chan_reg == $past(chan_reg) + 7'd1 ##2 ratio_reg == $past(rom_entry.ratio))
    else $error("search step wrong");
  a_search_wrap: assert property (mode_reg == MD_SEARCH && scnt_reg == CHANNEL_SEARCH_KEY_CYC - 1 && !evt_reg // RULE_11
    && chan_reg == hi_ch |=> chan_reg == $past(lo_ch))
    else $error("search did not wrap");
  a_stop_hold: assert property (evt_reg && code_reg == SEARCH_STOP_KEY // RULE_12
    |=> mode_reg == MD_MANUAL && $stable(chan_reg))
    else $error("stop did not halt");
  a_band_one: assert property ($onehot(band)) // RULE_19
    else $error("band not one-hot");
  a_chan_range: assert property (chan_reg >= lo_ch && chan_reg <= hi_ch) // RULE_17
    else $error("channel outside table");
  a_disp_mode: assert property (evt_reg && code_reg == DISPLAY_TOGGLE_KEY // RULE_06
    |=> show_freq_reg != $past(show_freq_reg) ##1 disp.fr_led == show_freq_reg && disp.ch_led != show_freq_reg)
    else $error("display toggle wrong");

endmodule // tcs_synth_ctrl
`default_nettype wire

// File: tcs_pkg.sv
// Constants and carrier types for the TV channel synthesizer controller.
// Assumes one 250 MHz clock and a synchronous active-low reset.
package tcs_pkg;

  // Clock and timing
  localparam int CLK_MHZ      = 250;
  localparam int SCAN_NS      = 1000;                              // Keypad row dwell
  localparam int SCAN_CYC     = (SCAN_NS * CLK_MHZ + 999) / 1000;  // Rounded up
  localparam int DEBOUNCE_MS  = 10;                                // Key settle time
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_MHZ * 1000;
  localparam int SEARCH_MS    = 350;                               // Search step interval
  localparam int SEARCH_CYC   = SEARCH_MS * CLK_MHZ * 1000;

  // Reference divider reload, plain default
  localparam logic [15:0] REF_DIV = 16'h0040;

  // Keypad codes
  localparam logic [3:0] DISPLAY_TOGGLE_KEY = 4'ha;
  localparam logic [3:0] CLEAR_DIGIT_KEY    = 4'hb;
  localparam logic [3:0] FINE_TUNE_DOWN_KEY = 4'hc;
  localparam logic [3:0] FINE_TUNE_UP_KEY   = 4'hd;
  localparam logic [3:0] SEARCH_STOP_KEY    = 4'he;
  localparam logic [3:0] CHANNEL_SEARCH_KEY = 4'hf;
  localparam logic [3:0] LAST_DIGIT_KEY     = 4'h9;

  // Channel ranges per country
  localparam logic [6:0] EUR_FIRST = 7'h00;
  localparam logic [6:0] EUR_LAST  = 7'h63;
  localparam logic [6:0] USA_FIRST = 7'h02;
  localparam logic [6:0] USA_LAST  = 7'h53;
  localparam logic [6:0] JPN_FIRST = 7'h01;
  localparam logic [6:0] JPN_LAST  = 7'h3e;

  // Regular UHF stretches: first channel, base ratio at first channel, Europe last channel
  localparam logic [6:0]  EUR_UHF_CH   = 7'h15;
  localparam logic [6:0]  EUR_UHF_END  = 7'h45;
  localparam logic [15:0] EUR_UHF_BASE = 16'h1fe2;
  localparam logic [6:0]  USA_UHF_CH   = 7'h0e;
  localparam logic [15:0] USA_UHF_BASE = 16'h2050;
  localparam logic [6:0]  JPN_UHF_CH   = 7'h0d;
  localparam logic [15:0] JPN_UHF_BASE = 16'h2120;

  // Ratio limits for fine tuning, reset values
  localparam logic [15:0] RATIO_MIN = 16'h0001;
  localparam logic [15:0] RATIO_MAX = 16'h3fff;
  localparam logic [15:0] RATIO_RST = 16'h0000;
  localparam logic [3:0]  BCD_BLANK = 4'hf;
  localparam logic [3:0]  DP_TENTHS = 4'h2;

  typedef enum logic [1:0] {CTRY_EUR, CTRY_USA, CTRY_JPN} tcs_country_t;
  typedef enum {KS_SCAN, KS_DEB, KS_HELD, KS_REL} tcs_key_st_t;
  typedef enum {MD_MANUAL, MD_SEARCH} tcs_mode_t;

  typedef struct packed {
    logic band_i;
    logic band_iii;
    logic band_uhf;
  } tcs_band_t;

  localparam tcs_band_t BND_LO  = '{1'b1, 1'b0, 1'b0};
  localparam tcs_band_t BND_HI  = '{1'b0, 1'b1, 1'b0};
  localparam tcs_band_t BND_UHF = '{1'b0, 1'b0, 1'b1};

  typedef struct packed {
    logic [15:0] ratio;
    tcs_band_t   band;
  } tcs_chan_t;

  localparam tcs_chan_t CHAN_RST = '{RATIO_RST, BND_LO};

  typedef struct packed {
    logic [15:0] digits;
    logic [3:0]  dp;
    logic        ch_led;
    logic        fr_led;
  } tcs_disp_t;

  typedef struct packed {
    logic up;
    logic dn;
  } tcs_pump_t;

endpackage

// File: tcs_chan_rom.sv
// Channel table: divide ratio and band for each channel of each country.
// Assumes the channel asked for exists; read data come one cycle later.
`timescale 1ns/1ps
`default_nettype none
module tcs_chan_rom (
  input  wire logic                mclk,    // Clock
  input  wire logic                nrst,    // Sync reset, active low
  input  wire tcs_pkg::tcs_country_t country, // Selected table
  input  wire logic [6:0]          chan,    // Channel number
  output var  tcs_pkg::tcs_chan_t  entry    // Registered table entry
);
  import tcs_pkg::*;

  tcs_chan_t   entry_next;
  logic [15:0] offs;

  // Regular UHF stretches by formula, irregular channels listed
  always_comb begin
    offs = 16'h0000;
    entry_next = CHAN_RST;
    case (country)
      CTRY_USA: begin
        offs = {9'h000, chan} - {9'h000, USA_UHF_CH};
        entry_next = '{USA_UHF_BASE + (offs << 6) + (offs << 5), BND_UHF};
        case (chan)
          7'd2:  entry_next = '{16'h0650, BND_LO};
          7'd3:  entry_next = '{16'h06b0, BND_LO};
          7'd4:  entry_next = '{16'h0710, BND_LO};
          7'd5:  entry_next = '{16'h07b0, BND_LO};
          7'd6:  entry_next = '{16'h0810, BND_LO};
          7'd7:  entry_next = '{16'h0dd0, BND_HI};
          7'd8:  entry_next = '{16'h0e30, BND_HI};
          7'd9:  entry_next = '{16'h0e90, BND_HI};
          7'd10: entry_next = '{16'h0ef0, BND_HI};
          7'd11: entry_next = '{16'h0f50, BND_HI};
          7'd12: entry_next = '{16'h0fb0, BND_HI};
          7'd13: entry_next = '{16'h1010, BND_HI};
          default: ;
        endcase
      end
      CTRY_JPN: begin
        offs = {9'h000, chan} - {9'h000, JPN_UHF_CH};
        entry_next = '{JPN_UHF_BASE + (offs << 6) + (offs << 5), BND_UHF};
        case (chan)
          7'd1:  entry_next = '{16'h0960, BND_LO};
          7'd2:  entry_next = '{16'h09c0, BND_LO};
          7'd3:  entry_next = '{16'h0a20, BND_LO};
          7'd4:  entry_next = '{16'h0e60, BND_HI};
          7'd5:  entry_next = '{16'h0ec0, BND_HI};
          7'd6:  entry_next = '{16'h0f20, BND_HI};
          7'd7:  entry_next = '{16'h0f80, BND_HI};
          7'd8:  entry_next = '{16'h0fc0, BND_HI};
          7'd9:  entry_next = '{16'h1020, BND_HI};
          7'd10: entry_next = '{16'h1080, BND_HI};
          7'd11: entry_next = '{16'h10e0, BND_HI};
          7'd12: entry_next = '{16'h1140, BND_HI};
          default: ;
        endcase
      end
      default: begin
        offs = {9'h000, chan} - {9'h000, EUR_UHF_CH};
        if (chan >= EUR_UHF_CH && chan <= EUR_UHF_END) begin
          entry_next = '{EUR_UHF_BASE + (offs << 7), BND_UHF};
        end
        case (chan)
          7'd0:  entry_next = '{16'h14b2, BND_HI};
          7'd1:  entry_next = '{16'h0552, BND_LO};
          7'd2:  entry_next = '{16'h0572, BND_LO};
          7'd3:  entry_next = '{16'h05e2, BND_LO};
          7'd4:  entry_next = '{16'h0652, BND_LO};
          7'd5:  entry_next = '{16'h0d62, BND_HI};
          7'd6:  entry_next = '{16'h0dd2, BND_HI};
          7'd7:  entry_next = '{16'h0e42, BND_HI};
          7'd8:  entry_next = '{16'h0eb2, BND_HI};
          7'd9:  entry_next = '{16'h0f22, BND_HI};
          7'd10: entry_next = '{16'h0f92, BND_HI};
          7'd11: entry_next = '{16'h1002, BND_HI};
          7'd12: entry_next = '{16'h1072, BND_HI};
          7'd13: entry_next = '{16'h05ca, BND_LO};
          7'd14: entry_next = '{16'h0652, BND_LO};
          7'd15: entry_next = '{16'h0792, BND_LO};
          7'd16: entry_next = '{16'h0d62, BND_HI};
          7'd17: entry_next = '{16'h0de2, BND_HI};
          7'd18: entry_next = '{16'h0e72, BND_HI};
          7'd19: entry_next = '{16'h0f02, BND_HI};
          7'd20: entry_next = '{16'h0f92, BND_HI};
          7'd70: entry_next = '{16'h0602, BND_LO};
          7'd71: entry_next = '{16'h0672, BND_LO};
          7'd72: entry_next = '{16'h07d2, BND_LO};
          7'd73: entry_next = '{16'h0862, BND_LO};
          7'd74: entry_next = '{16'h08d2, BND_LO};
          7'd75: entry_next = '{16'h0b12, BND_HI};
          7'd76: entry_next = '{16'h0f82, BND_HI};
          7'd77: entry_next = '{16'h0ff2, BND_HI};
          7'd78: entry_next = '{16'h06c2, BND_LO};
          7'd79: entry_next = '{16'h0732, BND_LO};
          7'd80: entry_next = '{16'h07a2, BND_LO};
          7'd81: entry_next = '{16'h0902, BND_LO};
          7'd82: entry_next = '{16'h0972, BND_HI};
          7'd83: entry_next = '{16'h09e2, BND_HI};
          7'd84: entry_next = '{16'h0a52, BND_HI};
          7'd85: entry_next = '{16'h0ac2, BND_HI};
          7'd86: entry_next = '{16'h0b32, BND_HI};
          7'd87: entry_next = '{16'h0ba2, BND_HI};
          7'd88: entry_next = '{16'h0c12, BND_HI};
          7'd89: entry_next = '{16'h0c82, BND_HI};
          7'd90: entry_next = '{16'h0cf2, BND_HI};
          7'd91: entry_next = '{16'h10e2, BND_HI};
          7'd92: entry_next = '{16'h1152, BND_HI};
          7'd93: entry_next = '{16'h11c2, BND_HI};
          7'd94: entry_next = '{16'h1232, BND_HI};
          7'd95: entry_next = '{16'h12a2, BND_HI};
          7'd96: entry_next = '{16'h1312, BND_HI};
          7'd97: entry_next = '{16'h1382, BND_HI};
          7'd98: entry_next = '{16'h13f2, BND_HI};
          7'd99: entry_next = '{16'h1462, BND_HI};
          default: ;
        endcase
      end
    endcase
  end

  // Registered read port
  always_ff @(posedge mclk) begin
    if (!nrst) entry <= CHAN_RST;
    else entry <= entry_next;
  end

endmodule // tcs_chan_rom
`default_nettype wire

// File: tcs_keypad_model.sv
// Keypad and prescaler model for the synthesizer controller.
// Assumes one key held at a time; columns pulled high.
`timescale 1ns/1ps
`default_nettype none
module tcs_keypad_model (
  input  wire logic       mclk,      // Clock
  input  wire logic [3:0] key_row_n, // Row drive
  input  wire logic       press,     // Key held
  input  wire logic [3:0] key,       // Key code
  output var  logic [3:0] key_col_n, // Columns
  output var  logic       fin        // Prescaled input
);
  logic [1:0] div_reg = 2'h0;
  // Held key pulls its column low on its own row only
  always_comb begin
    key_col_n = 4'hf;
    if (press && !key_row_n[key[3:2]]) key_col_n[key[1:0]] = 1'b0;
  end
  // Prescaler divides the oscillator down
  always_ff @(posedge mclk) div_reg <= div_reg + 2'h1;
  assign fin = div_reg[1];
endmodule // tcs_keypad_model
`default_nettype wire

// File: tb_top.sv
// Testbench for the synthesizer controller, Europe, USA and Japan tables.
// Assumes the keypad model is compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tcs_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        press = 1'b0;
  logic [3:0]  key = 4'h0;
  logic        country_sel_a = 1'b1;
  logic        country_sel_b = 1'b0;
  logic [3:0]  key_col_n;
  logic [3:0]  key_row_n;
  logic        fin;
  logic [7:0]  ratio_hi;
  logic [7:0]  ratio_lo;
  logic [15:0] ratio;
  tcs_pump_t   pump;
  tcs_band_t   band;
  tcs_disp_t   disp;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  assign ratio = {ratio_hi, ratio_lo};
  always #2 mclk = ~mclk;
  tcs_synth_ctrl #(.DEB_CYC(4), .CHANNEL_SEARCH_KEY_CYC(20)) tcs_synth_ctrl_inst (.mclk(mclk), .nrst(nrst),
    .country_sel_a(country_sel_a), .country_sel_b(country_sel_b), .cfg_strap_0(1'b0), .cfg_strap_1(1'b1),
    .cfg_strap_2(1'b1), .key_col_n(key_col_n), .fin(fin), .key_row_n(key_row_n),
    .ratio_hi(ratio_hi), .ratio_lo(ratio_lo), .pump(pump), .band(band), .disp(disp));
  tcs_keypad_model tcs_keypad_model_inst (.mclk(mclk), .key_row_n(key_row_n), .press(press),
    .key(key), .key_col_n(key_col_n), .fin(fin));
  // Compare and count
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One press, held past scan and debounce, then released
  task automatic press_key(input logic [3:0] k);
    @(posedge mclk);
    key <= k;
    press <= 1'b1;
    repeat (1100) @(posedge mclk);
    press <= 1'b0;
    repeat (1100) @(posedge mclk);
  endtask
  task automatic t_reset();
    chk({ratio, band}, {16'h14b2, BND_HI});
    chk(disp, {16'hff00, 4'h0, 1'b1, 1'b0});
  endtask
  // View toggle and fine tuning; one step leaves the display alone
  task automatic t_tune();
    press_key(DISPLAY_TOGGLE_KEY);
    chk(disp, {16'h3311, DP_TENTHS, 1'b0, 1'b1});
    chk(pump, 2'b10);
    press_key(FINE_TUNE_UP_KEY);
    chk(ratio, 16'h14b3);
    chk(disp.digits, 16'h3311);
    press_key(FINE_TUNE_DOWN_KEY);
    chk(ratio, 16'h14b2);
    press_key(DISPLAY_TOGGLE_KEY);
    chk(disp, {16'hff00, 4'h0, 1'b1, 1'b0});
  endtask
  task automatic t_entry();
    press_key(4'h2);
    press_key(4'h1);
    chk({ratio, band}, {16'h1fe2, BND_UHF});
    press_key(4'h1);
    press_key(CLEAR_DIGIT_KEY);
    press_key(4'h0);
    press_key(4'h1);
    chk({ratio, band}, {16'h0552, BND_LO});
  endtask
  // Search from the last channel wraps, steps, and stops on request
  task automatic t_search();
    int n;
    logic [15:0] held;
    press_key(4'h9);
    press_key(4'h9);
    chk({ratio, band}, {16'h1462, BND_HI});
    @(posedge mclk);
    key <= CHANNEL_SEARCH_KEY;
    press <= 1'b1;
    for (n = 0; n < 1100 && ratio !== 16'h14b2; n++) @(posedge mclk);
    chk(ratio, 16'h14b2);
    for (n = 0; n < 30 && ratio !== 16'h0552; n++) @(posedge mclk);
    chk(ratio, 16'h0552);
    press <= 1'b0;
    repeat (1100) @(posedge mclk);
    press_key(DISPLAY_TOGGLE_KEY);
    chk(disp.fr_led, 1'b1);
    press_key(SEARCH_STOP_KEY);
    held = ratio;
    repeat (200) @(posedge mclk);
    chk(ratio, held);
  endtask
  // Mid-run reset with new country straps
  task automatic restrap(input logic a, input logic b);
    @(posedge mclk);
    country_sel_a <= a;
    country_sel_b <= b;
    nrst <= 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask
  // USA table: valid entry tunes, missing channel falls back to 02
  task automatic t_usa();
    restrap(1'b0, 1'b1);
    chk({ratio, band}, {16'h0650, BND_LO});
    chk(disp, {16'hff02, 4'h0, 1'b1, 1'b0});
    press_key(4'h1);
    press_key(4'h4);
    chk({ratio, band}, {16'h2050, BND_UHF});
    press_key(4'h9);
    press_key(4'h8);
    chk({ratio, band}, {16'h0650, BND_LO});
    chk(disp, {16'hff02, 4'h0, 1'b1, 1'b0});
  endtask
  // Japan table starts at channel 01
  task automatic t_japan();
    restrap(1'b1, 1'b1);
    chk({ratio, band}, {16'h0960, BND_LO});
    chk(disp, {16'hff01, 4'h0, 1'b1, 1'b0});
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (5) @(posedge mclk);
    t_reset();
    t_tune();
    t_entry();
    t_search();
    t_usa();
    t_japan();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
